// file: design/ppm_pkg.sv
package ppm_pkg;

   // Master mode encodings of the two-bit mode field
   localparam logic [1:0] MODE_MASTER2 = 2'h2;
   localparam logic [1:0] MODE_MASTER1 = 2'h3;

   // Address multiplex field encodings
   localparam logic [1:0] MUX_DEMUX = 2'h0;
   localparam logic [1:0] MUX_PART = 2'h1;
   localparam logic [1:0] MUX_FULL = 2'h2;

   // Address pin positions with a second role
   localparam int PIN_LATCH_LO = 0;
   localparam int PIN_LATCH_HI = 1;
   localparam int PIN_CS1 = 14;
   localparam int PIN_CS2 = 15;
   localparam int HIGH_BYTE_POS = 8;

   // Clocks each data strobe stands; covers the two-flop input delay
   localparam logic [2:0] DATA_PHASE_CYCLES = 3'h4;
   localparam logic [2:0] DATA_PHASE_LAST = DATA_PHASE_CYCLES - 3'h1;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR_LO,
      PH_ADDR_HI,
      PH_DATA_LO,
      PH_DATA_HI
   } ppm_phase_e;

   // Software configuration, polarity bits are 1 for active high
   typedef struct packed {
      logic port_enable_bit;
      logic [1:0] master_mode;
      logic wide_data_select;
      logic [1:0] addr_mux_select;
      logic byte_enable_pin_en;
      logic write_strobe_pin_en;
      logic read_strobe_pin_en;
      logic [15:0] address_pin_enables;
      logic cs1_on_pin;
      logic cs2_on_pin;
      logic pol_read;
      logic pol_write;
      logic pol_byte_enable;
      logic pol_latch;
      logic pol_cs1;
      logic pol_cs2;
   } ppm_cfg_s;

   // Pin side of the port, enables of 1 give the pin to the port; data_oe_n is active low, 0 drives the data pins
   typedef struct packed {
      logic [7:0] data_out;
      logic data_oe_n;
      logic [15:0] addr_out;
      logic [15:0] addr_en;
      logic rd_line;
      logic rd_en;
      logic wr_line;
      logic wr_en;
      logic be_line;
      logic be_en;
   } ppm_pins_s;

   typedef struct packed {
      ppm_phase_e phase;
      logic [2:0] cnt;
      logic is_write;
      logic wide;
      logic cs1;
      logic cs2;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic busy;
      logic done;
      ppm_pins_s pins;
   } ppm_state_s;

   localparam ppm_pins_s PINS_RESET = '{
      data_out: 8'h00, data_oe_n: 1'b1, addr_out: 16'h0000,
      addr_en: 16'h0000, default: 1'b0};

   localparam ppm_state_s STATE_RESET = '{
      phase: PH_IDLE, cnt: 3'h0, addr: 16'h0000, wdata: 16'h0000,
      rdata: 16'h0000, pins: PINS_RESET, default: 1'b0};

endpackage : ppm_pkg

// file: design/ppm_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ppm_sync
   import ppm_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;

   // Two flops; only the second one is read outside
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i)
      begin
         stage1 <= '0;
         sync_o <= '0;
      end
      else
      begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end

endmodule : ppm_sync

`default_nettype wire

// file: design/ppm_master.sv
`timescale 1ns/1ns
`default_nettype none

module ppm_master
   import ppm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire ppm_cfg_s cfg_i,
   input wire logic start_i,
   input wire logic write_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic [7:0] data_pins_i,
   output logic [15:0] rdata_o,
   output logic busy_o,
   output logic done_o,
   output ppm_pins_s pins_o
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Turn an active level into the pin level for its polarity bit
   function automatic logic apply_pol(input logic act, input logic pol);
      return pol ? act : !act;
   endfunction : apply_pol

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   ppm_state_s st;
   ppm_state_s next_st;
   logic [7:0] data_sync;
   logic active;
   logic mode1;
   logic in_addr_lo;
   logic in_addr_hi;
   logic in_data;
   logic xfer;
   logic rd_act;
   logic wr_act;
   logic cs1_pin;
   logic cs2_pin;
   logic all_pin;
   logic alh_pin;
   logic [15:0] addr_masked;

   ////////////////////////////////////////////////////////////////////////
   // Input synchroniser for the data pins

   ppm_sync #(
      .WIDTH(8)
   ) u_data_sync (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .async_i(data_pins_i),
      .sync_o(data_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mode decode

   // Port is master in either of the two master encodings while enabled
   assign active = cfg_i.port_enable_bit && cfg_i.master_mode[1];
   assign mode1 = (cfg_i.master_mode == MODE_MASTER1);

   // Address with select bits cleared where pins act as selects
   always_comb
   begin
      addr_masked = addr_i;
      if (cfg_i.cs1_on_pin)
      begin
         addr_masked[PIN_CS1] = 1'b0;
      end
      if (cfg_i.cs2_on_pin)
      begin
         addr_masked[PIN_CS2] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer and pin drive, all state in one struct

   always_comb
   begin
      next_st = st;
      next_st.done = 1'b0;
      unique case (st.phase)
         PH_IDLE:
         begin
            if (start_i && active)
            begin
               // Latch the transfer into the data/address pair
               next_st.addr = addr_masked;
               next_st.wdata = wdata_i;
               next_st.is_write = write_i;
               next_st.wide = cfg_i.wide_data_select;
               // Top address bits steer the two chip selects
               next_st.cs1 = addr_i[PIN_CS1] && cfg_i.cs1_on_pin;
               next_st.cs2 = addr_i[PIN_CS2] && cfg_i.cs2_on_pin;
               next_st.busy = 1'b1;
               next_st.cnt = 3'h0;
               if (cfg_i.addr_mux_select == MUX_DEMUX)
               begin
                  next_st.phase = PH_DATA_LO;
               end
               else
               begin
                  next_st.phase = PH_ADDR_LO;
               end
            end
         end
         PH_ADDR_LO:
         begin
            if (cfg_i.addr_mux_select == MUX_FULL)
            begin
               next_st.phase = PH_ADDR_HI;
            end
            else
            begin
               next_st.phase = PH_DATA_LO;
            end
         end
         PH_ADDR_HI:
         begin
            next_st.phase = PH_DATA_LO;
         end
         PH_DATA_LO:
         begin
            if (st.cnt == DATA_PHASE_LAST)
            begin
               // Low byte always goes first
               next_st.rdata[7:0] = data_sync;
               next_st.cnt = 3'h0;
               if (st.wide)
               begin
                  next_st.phase = PH_DATA_HI;
               end
               else
               begin
                  next_st.phase = PH_IDLE;
                  next_st.busy = 1'b0;
                  next_st.done = 1'b1;
               end
            end
            else
            begin
               next_st.cnt = st.cnt + 3'h1;
            end
         end
         PH_DATA_HI:
         begin
            if (st.cnt == DATA_PHASE_LAST)
            begin
               next_st.rdata[15:8] = data_sync;
               next_st.cnt = 3'h0;
               next_st.phase = PH_IDLE;
               next_st.busy = 1'b0;
               next_st.done = 1'b1;
            end
            else
            begin
               next_st.cnt = st.cnt + 3'h1;
            end
         end
      endcase
      // Leaving master operation drops any transfer at once
      if (!active)
      begin
         next_st.phase = PH_IDLE;
         next_st.busy = 1'b0;
         next_st.cnt = 3'h0;
      end

      // Phase flags from the coming phase so pins align with it
      in_addr_lo = (next_st.phase == PH_ADDR_LO);
      in_addr_hi = (next_st.phase == PH_ADDR_HI);
      in_data = (next_st.phase == PH_DATA_LO)
         || (next_st.phase == PH_DATA_HI);
      xfer = (next_st.phase != PH_IDLE);

      // Strobe levels for the two schemes on shared pins
      if (mode1)
      begin
         rd_act = xfer && !next_st.is_write;
         wr_act = in_data;
      end
      else
      begin
         rd_act = in_data && !next_st.is_write;
         wr_act = in_data && next_st.is_write;
      end
      next_st.pins.rd_line = apply_pol(rd_act, cfg_i.pol_read);
      next_st.pins.wr_line = apply_pol(wr_act, cfg_i.pol_write);
      next_st.pins.be_line = apply_pol(next_st.phase == PH_DATA_HI,
         cfg_i.pol_byte_enable);
      all_pin = apply_pol(in_addr_lo, cfg_i.pol_latch);
      alh_pin = apply_pol(in_addr_hi, cfg_i.pol_latch);
      cs1_pin = apply_pol(xfer && next_st.cs1, cfg_i.pol_cs1);
      cs2_pin = apply_pol(xfer && next_st.cs2, cfg_i.pol_cs2);

      // Data pins carry address bytes, then write data
      if (in_addr_lo)
      begin
         next_st.pins.data_out = next_st.addr[7:0];
      end
      else if (in_addr_hi)
      begin
         next_st.pins.data_out = next_st.addr[15:8];
      end
      else if (next_st.phase == PH_DATA_HI)
      begin
         next_st.pins.data_out = next_st.wdata[15:8];
      end
      else
      begin
         next_st.pins.data_out = next_st.wdata[7:0];
      end
      next_st.pins.data_oe_n = !(in_addr_lo || in_addr_hi
         || (in_data && next_st.is_write));

      // Address pins: address bits, latch strobes or chip selects
      for (int i = 0; i < 16; i++)
      begin
         unique case (cfg_i.addr_mux_select)
            MUX_DEMUX: next_st.pins.addr_out[i] = next_st.addr[i];
            MUX_PART: next_st.pins.addr_out[i] =
               (i >= HIGH_BYTE_POS) && next_st.addr[i];
            default: next_st.pins.addr_out[i] = 1'b0;
         endcase
      end
      if (cfg_i.addr_mux_select != MUX_DEMUX)
      begin
         next_st.pins.addr_out[PIN_LATCH_LO] = all_pin;
      end
      if (cfg_i.addr_mux_select == MUX_FULL)
      begin
         next_st.pins.addr_out[PIN_LATCH_HI] = alh_pin;
      end
      if (cfg_i.cs1_on_pin)
      begin
         next_st.pins.addr_out[PIN_CS1] = cs1_pin;
      end
      if (cfg_i.cs2_on_pin)
      begin
         next_st.pins.addr_out[PIN_CS2] = cs2_pin;
      end

      // Pin ownership: set bit gives pin to port, clear returns it
      next_st.pins.addr_en = cfg_i.address_pin_enables
         & {16{active}};
      next_st.pins.rd_en = cfg_i.read_strobe_pin_en && active;
      next_st.pins.wr_en = cfg_i.write_strobe_pin_en && active;
      next_st.pins.be_en = cfg_i.byte_enable_pin_en && active;
   end

   // State register with synchronous reset
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i)
      begin
         st <= STATE_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register

   assign rdata_o = st.rdata;
   assign busy_o = st.busy;
   assign done_o = st.done;
   assign pins_o = st.pins;

endmodule : ppm_master

`default_nettype wire

// file: verif/ppm_master_chk.sv
`timescale 1ns/1ns
`default_nettype none

module ppm_master_chk
   import ppm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire ppm_cfg_s cfg_i,
   input wire logic start_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire ppm_pins_s pins_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   logic act;
   logic take;
   logic [3:0] cyc;
   logic [3:0] exp_n;
   assign act = cfg_i.port_enable_bit && cfg_i.master_mode[1];
   assign take = start_i && !busy_o && act;

   ////////////////////////////////////////////////////////////////////////
   // Age of the running transfer and its expected length
   always_ff @(posedge ref_clk_i)
   begin
      if (!rstn_i)
      begin
         cyc <= 4'h0;
         exp_n <= 4'h0;
      end
      else if (take)
      begin
         cyc <= 4'h1;
         exp_n <= (cfg_i.wide_data_select ? 4'h8 : 4'h4)
            + (cfg_i.addr_mux_select == 2'h2 ? 4'h2
            : {3'h0, cfg_i.addr_mux_select != 2'h0});
      end
      else
         cyc <= busy_o ? cyc + 4'h1 : 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   property p_done_when;
      done_o |-> cyc == exp_n + 4'h1;
   endproperty
   a_done_when: assert property (p_done_when)
      else $error("done at wrong cycle");
   property p_done_due;
      cyc != 4'h0 && cyc == exp_n + 4'h1 |-> done_o;
   endproperty
   a_done_due: assert property (p_done_due)
      else $error("done missing");
   property p_take_busy;
      take |=> busy_o [*3];
   endproperty
   a_take_busy: assert property (p_take_busy)
      else $error("accepted start without busy");
   property p_busy_hold;
      busy_o && act |=> busy_o || done_o;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("transfer dropped");
   property p_abort;
      busy_o && !cfg_i.port_enable_bit |=> !busy_o && !done_o;
   endproperty
   a_abort: assert property (p_abort)
      else $error("no abort");
   property p_idle_oe;
      !busy_o |-> pins_o.data_oe_n;
   endproperty
   a_idle_oe: assert property (p_idle_oe)
      else $error("data driven while idle");
   property p_pin_en;
      $past(rstn_i) |=> pins_o.addr_en == ($past(act)
         ? $past(cfg_i.address_pin_enables) : 16'h0000)
         && pins_o.rd_en == $past(act && cfg_i.read_strobe_pin_en)
         && pins_o.wr_en == $past(act && cfg_i.write_strobe_pin_en)
         && pins_o.be_en == $past(act && cfg_i.byte_enable_pin_en);
   endproperty
   a_pin_en: assert property (p_pin_en)
      else $error("pin enable wrong");
   property p_narrow_be;
      busy_o && !cfg_i.wide_data_select
         |-> pins_o.be_line == !cfg_i.pol_byte_enable;
   endproperty
   a_narrow_be: assert property (p_narrow_be)
      else $error("byte enable in narrow transfer");

   c_wide: cover property (take && cfg_i.wide_data_select);
   c_full: cover property (done_o && cfg_i.addr_mux_select == 2'h2);
   c_abort: cover property (busy_o && !cfg_i.port_enable_bit);
endmodule : ppm_master_chk

`default_nettype wire

// file: verif/ppm_ext_dev.sv
`timescale 1ns/1ns
`default_nettype none

module ppm_ext_dev
   import ppm_pkg::*;
(
   input wire logic ref_clk_i,
   input wire ppm_cfg_s cfg_i,
   input wire ppm_pins_s pins_i,
   input wire logic [15:0] rd_data_i,
   output logic [7:0] data_o,
   output logic [15:0] adr_seen_o,
   output logic [15:0] wr_seen_o
);
   logic en, dir, rd, wr, be, lat_lo, lat_hi;
   logic [7:0] last = 8'h5A;
   logic [7:0] byte_now;

   // Strobe decoding; the shared pin has one polarity bit
   assign en = pins_i.wr_line == cfg_i.pol_write;
   assign dir = pins_i.rd_line == cfg_i.pol_read;
   assign rd = cfg_i.master_mode[0] ? en && dir : dir;
   assign wr = cfg_i.master_mode[0] ? en && !dir : en;
   assign be = pins_i.be_line == cfg_i.pol_byte_enable;
   assign lat_lo = !pins_i.data_oe_n && cfg_i.addr_mux_select != 2'h0
      && pins_i.addr_out[0] == cfg_i.pol_latch;
   assign lat_hi = !pins_i.data_oe_n && cfg_i.addr_mux_select[1]
      && pins_i.addr_out[1] == cfg_i.pol_latch;
   // Drive read byte, otherwise a changed pattern
   assign byte_now = be ? rd_data_i[15:8] : rd_data_i[7:0];
   assign data_o = rd ? byte_now : ~last;

   ////////////////////////////////////////////////////////////////////////
   // Capture address and write bytes on their strobes
   always @(posedge ref_clk_i)
   begin
      if (rd)
         last <= byte_now;
      if (wr)
         wr_seen_o[be*8 +: 8] <= pins_i.data_out;
      if (lat_lo)
         adr_seen_o[7:0] <= pins_i.data_out;
      if (lat_hi)
         adr_seen_o[15:8] <= pins_i.data_out;
      if ((rd || wr) && cfg_i.addr_mux_select == 2'h0)
         adr_seen_o <= pins_i.addr_out;
      if ((rd || wr) && cfg_i.addr_mux_select == 2'h1)
         adr_seen_o[15:8] <= pins_i.addr_out[15:8];
   end
endmodule : ppm_ext_dev

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top
   import ppm_pkg::*;
;
   typedef struct {
      logic [1:0] mm;
      logic wide;
      logic [1:0] mux;
      logic wr;
      logic pol;
      logic [15:0] adr;
      logic [15:0] dat;
      logic [7:0] cyc;
   } ppm_row_s;
   // Mode, width, mux, write, polarity, address, data, length
   ppm_row_s rows [6] = '{
      '{2'h2, 1'b0, 2'h0, 1'b1, 1'b1, 16'h1234, 16'h00A5, 8'h04},
      '{2'h2, 1'b1, 2'h1, 1'b0, 1'b0, 16'h2345, 16'hC33C, 8'h09},
      '{2'h2, 1'b1, 2'h2, 1'b1, 1'b1, 16'hFFFF, 16'h5AA5, 8'h0A},
      '{2'h3, 1'b1, 2'h0, 1'b0, 1'b0, 16'h8001, 16'h0FF0, 8'h08},
      '{2'h3, 1'b0, 2'h2, 1'b0, 1'b1, 16'h4C3B, 16'h0096, 8'h06},
      '{2'h3, 1'b0, 2'h1, 1'b1, 1'b0, 16'h00FE, 16'h0069, 8'h05}};
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   ppm_cfg_s cfg = '0;
   logic start = 1'b0;
   logic wr = 1'b0;
   logic [15:0] adr = 16'h0000;
   logic [15:0] wdat = 16'h0000;
   logic [15:0] rd_data = 16'h0000;
   logic [7:0] dev_data, data_pins, n;
   logic [15:0] rdata, adr_seen, wr_seen, mask;
   logic busy, done;
   ppm_pins_s pins;
   int failures = 0;
   int check_count = 0;

   ppm_master ppm_master_inst (.ref_clk_i, .rstn_i, .cfg_i(cfg),
      .start_i(start), .write_i(wr), .addr_i(adr), .wdata_i(wdat),
      .data_pins_i(data_pins), .rdata_o(rdata), .busy_o(busy),
      .done_o(done), .pins_o(pins));
   ppm_ext_dev ppm_ext_dev_inst (.ref_clk_i, .cfg_i(cfg), .pins_i(pins),
      .rd_data_i(rd_data), .data_o(dev_data), .adr_seen_o(adr_seen),
      .wr_seen_o(wr_seen));
   // Data wire resolved from both drivers
   assign data_pins = pins.data_oe_n ? dev_data : pins.data_out;
   always #5 ref_clk_i = ~ref_clk_i;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop

   // Start held two edges so the second request meets a busy port
   task automatic run(input logic [15:0] a, input logic w);
      @(posedge ref_clk_i);
      adr <= a;
      wr <= w;
      start <= 1'b1;
      n = 8'h00;
      do
      begin
         @(posedge ref_clk_i);
         n++;
         if (n == 8'h02)
            start <= 1'b0;
      end while (!done && n < 8'h20);
   endtask : run

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      foreach (rows[i])
      begin
         cfg <= {1'b1, rows[i].mm, rows[i].wide, rows[i].mux, 3'h7,
            16'hFFFF, 2'h3, {6{rows[i].pol}}};
         rd_data <= rows[i].dat;
         wdat <= rows[i].dat;
         run(rows[i].adr, rows[i].wr);
         chk("cycles", {8'h00, n}, {8'h00, rows[i].cyc + 8'h02});
         mask = rows[i].wide ? 16'hFFFF : 16'h00FF;
         chk("addr", rows[i].mux == 2'h2 ? adr_seen : adr_seen & 16'h3FFF,
            rows[i].adr & 16'h3FFF);
         chk("data", (rows[i].wr ? wr_seen : rdata) & mask,
            rows[i].dat & mask);
      end
      // Not a master encoding: request ignored
      cfg.master_mode <= 2'h1;
      run(16'h0001, 1'b1);
      chk("refused", {8'h00, n}, 16'h0020);
      // Abort by clearing enable mid-transfer, request held while off
      cfg.master_mode <= 2'h2;
      @(posedge ref_clk_i);
      adr <= 16'h0002;
      wr <= 1'b1;
      start <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      chk("busy", {15'h0000, busy}, 16'h0001);
      cfg.port_enable_bit <= 1'b0;
      repeat (12)
      begin
         @(posedge ref_clk_i);
         chk("done", {15'h0000, done}, 16'h0000);
      end
      chk("busy", {15'h0000, busy}, 16'h0000);
      // Reset in mid-transfer
      cfg.port_enable_bit <= 1'b1;
      start <= 1'b0;
      run(16'h0003, 1'b0);
      repeat (3) @(posedge ref_clk_i);
      start <= 1'b1;
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk("pins", 16'(pins === PINS_RESET), 16'h0001);
      chk("rdata", rdata, 16'h0000);
      // Release again and run one write from the cleared state
      start <= 1'b0;
      wdat <= 16'h00C3;
      rstn_i <= 1'b1;
      run(16'h0004, 1'b1);
      chk("cycles", {8'h00, n}, 16'h0007);
      chk("data", wr_seen & 16'h00FF, 16'h00C3);
      report_and_stop();
   end

   // Watchdog well beyond the roughly 130 cycles the run needs
   initial
   begin
      #50000;
      failures++;
      report_and_stop();
   end
endmodule : tb_top

bind ppm_master ppm_master_chk ppm_master_chk_inst (.ref_clk_i, .rstn_i,
   .cfg_i, .start_i, .busy_o, .done_o, .pins_o);

`default_nettype wire
